// file: bench/sbat_arbiter_bench.sv
`default_nettype none

module sbat_arbiter_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic presclTick = 1'b0;
	logic [1:0] psc = 2'h0;
	logic rxLine;
	logic txInternal = 1'b1;
	logic txPin;
	logic pullLow = 1'b0;
	logic [7:0] rv;
	int errorCnt = 0;
	int nCompared = 0;

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// The prescaler pulses every third cycle, so it is told apart from the bus quarter.
	always @(posedge ref_clk) begin
		psc <= (psc == 2'h2) ? 2'h0 : psc + 2'h1;
		presclTick <= (psc == 2'h2);
	end

	sbat_arbiter uut (
		.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .presclTick(presclTick),
		.rxLine(rxLine), .txInternal(txInternal), .txPin(txPin)
	);

	sbat_bus_node node (.txPin(txPin), .pullLow(pullLow), .rxLine(rxLine));

	task automatic finishTest;
		$display("Compared %0d, mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finishTest

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		rv = regRdata;
	endtask : rd

	task automatic rc(input logic [1:0] a, input logic [7:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rc

	task automatic poll(input int b);
		for (int i = 0; i < 900; i++) begin
			rd(2'h0);
			if (rv[b] === 1'b1) begin
				return;
			end
		end
		errorCnt++;
		finishTest();
	endtask : poll

	// Overall limit of 20000 clock cycles.
	initial begin
		#800000;
		errorCnt++;
		finishTest();
	end

	initial begin
		cyc(16);
		arst_n <= 1'b1;
		rc(2'h0, 8'h00);
		rc(2'h1, 8'h00);
		rc(2'h2, 8'h00);
		wr(2'h2, 8'hFF);
		rc(2'h0, 8'h00);
		wr(2'h0, 8'h40);
		rc(2'h0, 8'h40);
		cyc(1);
		pullLow <= 1'b1;
		cyc(20);
		pullLow <= 1'b0;
		rc(2'h0, 8'h44);
		cyc(2077);
		pullLow <= 1'b1;
		poll(3);
		rc(2'h0, 8'h4A);
		rd(2'h1);
		chk({7'h00, rv >= 8'h0C && rv <= 8'h0E}, 8'h01);
		cyc(1);
		pullLow <= 1'b0;
		wr(2'h0, 8'h40);
		rc(2'h0, 8'h40);
		rc(2'h1, 8'h00);
		cyc(1);
		pullLow <= 1'b1;
		cyc(4);
		wr(2'h0, 8'h50);
		cyc(56);
		pullLow <= 1'b0;
		poll(3);
		rc(2'h0, 8'h58);
		rd(2'h1);
		chk({7'h00, rv >= 8'h08 && rv <= 8'h0B}, 8'h01);
		wr(2'h0, 8'h90);
		txInternal <= 1'b0;
		cyc(2);
		txInternal <= 1'b1;
		cyc(60);
		rc(2'h0, 8'h94);
		cyc(1);
		txInternal <= 1'b0;
		cyc(4);
		rc(2'h0, 8'h90);
		rc(2'h1, 8'h00);
		cyc(1);
		pullLow <= 1'b1;
		txInternal <= 1'b1;
		cyc(60);
		txInternal <= 1'b0;
		cyc(1);
		chk({7'h00, txPin}, 8'h01);
		rd(2'h0);
		chk(rv & 8'hE0, 8'hA0);
		cyc(1);
		pullLow <= 1'b0;
		wr(2'h0, 8'h80);
		rc(2'h0, 8'hA0);
		wr(2'h0, 8'h00);
		rc(2'h0, 8'h00);
		chk({7'h00, txPin}, 8'h00);
		wr(2'h0, 8'h80);
		pullLow <= 1'b1;
		txInternal <= 1'b1;
		cyc(200);
		rc(2'h0, 8'h84);
		cyc(40);
		rc(2'h0, 8'hA4);
		cyc(1);
		pullLow <= 1'b0;
		txInternal <= 1'b0;
		wr(2'h0, 8'h00);
		rc(2'h1, 8'h00);
		wr(2'h0, 8'hC0);
		pullLow <= 1'b1;
		cyc(20);
		rc(2'h0, 8'hC0);
		cyc(1);
		pullLow <= 1'b0;
		finishTest();
	end

endmodule : sbat_arbiter_bench

`default_nettype wire

// file: bench/sbat_bus_node.sv
`default_nettype none

module sbat_bus_node (
	input wire logic txPin,
	input wire logic pullLow,
	output logic rxLine
);
	timeunit 1ns;
	timeprecision 1ns;

	// The shared line has a pull-up, so a low from any node wins.
	assign rxLine = txPin & ~pullLow;

endmodule : sbat_bus_node

`default_nettype wire

// file: verilog/sbat_arbiter.sv
// Summary of operation
// - Nine-bit counter plus overflow bit, software controlled.
// - Mode field: idle, measure, arbitrate; 11 reserved.
// - Mode zero clears and holds the counter.
// - Lost flag cleared by writing upper mode zero.
// - Counter ticks on prescaler half or bus quarter.
// - Finished flag set on completion, write clears.
// - Running flag mirrors the counter counting.
// - Overflow flag sticky, any control write clears.
// - Counter top bit readable, control write clears.
// - Counter low byte readable, control write clears.
// - Bus-clock measure: falling edge to falling edge.
// - Prescaler measure: low level until rising edge.
// - Arbitration restarts counter on transmit rising edge.
// - Sample receive at set count; low sets lost.
// - Lost flag forces transmit pin high.
// - Transmit low before sensed low resets counter.
//
// Our own choices: the address map and strobed register access.
`include "sbat_defines.svh"
`default_nettype none

module sbat_arbiter
	import sbat_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic presclTick,
	input wire logic rxLine,
	input wire logic txInternal,
	output logic txPin
);

	sbat_regs_s q, d;
	logic rxSync;
	logic wrCtrl;
	logic tick;
	logic rxFall;
	logic rxRise;
	logic txRise;
	logic txFall;
	logic [8:0] cntNext;
	logic [8:0] sampleAt;
	logic hitSample;
	logic setLost;
	logic measStop;
	logic restart;

	function automatic logic fallEdge(input logic prev, input logic cur);
		fallEdge = prev && !cur;
	endfunction : fallEdge

	function automatic sbat_state_e startState(input logic [1:0] mode);
		case (mode)
			`SBAT_MODE_MEAS: startState = ST_MEAS_WAIT;
			`SBAT_MODE_ARB: startState = ST_ARB_WAIT;
			default: startState = ST_IDLE;
		endcase
	endfunction : startState

	sbat_rx_sync u_rx_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.rxRaw(rxLine),
		.rxSync(rxSync)
	);

	always_comb begin
		d = q;
		wrCtrl = regWr && (regAddr == `SBAT_OFS_CTRL);
		rxFall = fallEdge(q.rxPrev, rxSync);
		rxRise = fallEdge(rxSync, q.rxPrev);
		txFall = fallEdge(q.txPrev, txInternal);
		txRise = fallEdge(txInternal, q.txPrev);
		d.rxPrev = rxSync;
		d.txPrev = txInternal;

		// Counter time base: bus clock over four, or every second prescaler tick.
		d.div = 2'(q.div + `SBAT_DIV_ONE);
		if (presclTick) begin
			d.pscHalf = !q.pscHalf;
		end
		tick = q.aclk ? (presclTick && q.pscHalf) : (q.div == `SBAT_DIV4_LAST);

		sampleAt = q.aclk ? `SBAT_SAMPLE_PSC : `SBAT_SAMPLE_BUS;
		cntNext = 9'(q.cnt + `SBAT_CNT_ONE);
		hitSample = (q.state == ST_ARB_RUN) && q.run && tick && (cntNext == sampleAt);
		setLost = hitSample && !rxSync;
		measStop = q.aclk ? rxRise : rxFall;

		// Software write: clears go first so that hardware events below win.
		if (wrCtrl) begin
			d.mode = regWdata[`SBAT_BIT_AM1:`SBAT_BIT_AM0];
			d.aclk = regWdata[`SBAT_BIT_ACLK];
			if (!regWdata[`SBAT_BIT_AM1]) begin
				d.lost = 1'b0;
			end
			d.fin = 1'b0;
			d.ovfl = 1'b0;
			d.cnt = `SBAT_RST_CNT;
		end

		// Counting and wrap into the sticky overflow bit.
		if (q.run && tick) begin
			d.cnt = 9'(d.cnt + `SBAT_CNT_ONE);
			if (q.cnt == `SBAT_CNT_MAX) begin
				d.ovfl = 1'b1;
			end
		end

		case (q.state)
			ST_IDLE: begin
				d.run = 1'b0;
				if (q.mode == `SBAT_MODE_IDLE) begin
					d.cnt = `SBAT_RST_CNT;
				end
			end
			ST_MEAS_WAIT: begin
				if (q.aclk ? !rxSync : rxFall) begin
					d.cnt = `SBAT_RST_CNT;
					d.run = 1'b1;
					d.state = ST_MEAS_RUN;
				end
			end
			ST_MEAS_RUN: begin
				if (measStop) begin
					d.run = 1'b0;
					d.fin = 1'b1;
					d.state = ST_MEAS_DONE;
				end
			end
			ST_MEAS_DONE: begin
				d.run = 1'b0;
			end
			ST_ARB_WAIT: begin
				if (txRise) begin
					d.cnt = `SBAT_RST_CNT;
					d.run = 1'b1;
					d.seenLow = 1'b0;
					d.state = ST_ARB_RUN;
				end
			end
			ST_ARB_RUN: begin
				if (setLost) begin
					d.lost = 1'b1;
					d.seenLow = 1'b1;
				end
				if (txRise) begin
					d.cnt = `SBAT_RST_CNT;
					d.run = 1'b1;
					d.seenLow = 1'b0;
				end else if (txFall && !q.seenLow && !setLost) begin
					d.cnt = `SBAT_RST_CNT;
					d.run = 1'b0;
					d.state = ST_ARB_WAIT;
				end
			end
			default: begin
				d.run = 1'b0;
				d.state = ST_IDLE;
			end
		endcase

		// A new mode or clock source, or a write after a finished measurement,
		// starts the selected mode afresh from a cleared counter.
		restart = wrCtrl && ((d.mode != q.mode) || (d.aclk != q.aclk)
			|| (q.state == ST_MEAS_DONE));
		if (restart) begin
			d.state = startState(d.mode);
			d.run = 1'b0;
			d.seenLow = 1'b0;
			d.cnt = `SBAT_RST_CNT;
		end

		// Read data stand for the single cycle after the read strobe.
		d.rdata = `SBAT_RST_BYTE;
		if (regRd) begin
			case (regAddr)
				`SBAT_OFS_CTRL: begin
					d.rdata[`SBAT_BIT_AM1:`SBAT_BIT_AM0] = q.mode;
					d.rdata[`SBAT_BIT_LOST] = q.lost;
					d.rdata[`SBAT_BIT_ACLK] = q.aclk;
					d.rdata[`SBAT_BIT_FIN] = q.fin;
					d.rdata[`SBAT_BIT_RUN] = q.run;
					d.rdata[`SBAT_BIT_OVFL] = q.ovfl;
					d.rdata[`SBAT_BIT_MSB] = q.cnt[8];
				end
				`SBAT_OFS_DATA: begin
					d.rdata = q.cnt[7:0];
				end
				default: begin
					d.rdata = `SBAT_RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{
				mode: `SBAT_RST_MODE,
				aclk: 1'b0,
				lost: 1'b0,
				fin: 1'b0,
				run: 1'b0,
				ovfl: 1'b0,
				cnt: `SBAT_RST_CNT,
				div: `SBAT_RST_DIV,
				pscHalf: 1'b0,
				rxPrev: `SBAT_RX_IDLE,
				txPrev: `SBAT_TX_IDLE,
				seenLow: 1'b0,
				state: ST_IDLE,
				rdata: `SBAT_RST_BYTE
			};
		end else begin
			q <= d;
		end
	end

	assign regRdata = q.rdata;
	// While arbitration is lost the bus sees a recessive high.
	assign txPin = txInternal || q.lost;

	sequence s_sampleLow;
		setLost && !wrCtrl;
	endsequence

	sequence s_lostSeen;
		q.lost ##0 txPin;
	endsequence

	sequence s_measEnd;
		(q.state == ST_MEAS_RUN) && measStop;
	endsequence

	property p_overflow;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.run && tick && (q.cnt == `SBAT_CNT_MAX)) |=> q.ovfl;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("counter wrap did not set overflow");

	property p_reservedIdle;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.mode != `SBAT_MODE_MEAS) && (q.mode != `SBAT_MODE_ARB) |-> (q.state == ST_IDLE);
	endproperty
	a_reservedIdle: assert property (p_reservedIdle)
		else $error("idle or reserved mode left the idle state");

	property p_idleHold;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.mode == `SBAT_MODE_IDLE) && !wrCtrl |=> (q.cnt == `SBAT_RST_CNT) && !q.run;
	endproperty
	a_idleHold: assert property (p_idleHold)
		else $error("idle mode did not hold counter cleared");

	property p_lostClear;
		@(posedge ref_clk) disable iff (!arst_n)
		wrCtrl && !regWdata[`SBAT_BIT_AM1] && !setLost |=> !q.lost;
	endproperty
	a_lostClear: assert property (p_lostClear)
		else $error("upper mode bit zero did not clear lost flag");

	property p_quarterTick;
		@(posedge ref_clk) disable iff (!arst_n)
		(!q.aclk && tick) |=> (!tick || q.aclk) [*3];
	endproperty
	a_quarterTick: assert property (p_quarterTick)
		else $error("bus quarter tick came too early");

	property p_writeClears;
		@(posedge ref_clk) disable iff (!arst_n)
		wrCtrl && !q.run |=> !q.fin && !q.ovfl && (q.cnt == `SBAT_RST_CNT);
	endproperty
	a_writeClears: assert property (p_writeClears)
		else $error("control write left flags or counter set");

	property p_runRead;
		@(posedge ref_clk) disable iff (!arst_n)
		regRd && (regAddr == `SBAT_OFS_CTRL)
			|=> (regRdata[`SBAT_BIT_RUN] == $past(q.run))
			&& (regRdata[`SBAT_BIT_MSB] == $past(q.cnt[8]));
	endproperty
	a_runRead: assert property (p_runRead)
		else $error("control read does not show run or top bit");

	property p_measEnd;
		@(posedge ref_clk) disable iff (!arst_n)
		s_measEnd |=> q.fin && !q.run;
	endproperty
	a_measEnd: assert property (p_measEnd)
		else $error("measurement end did not stop and flag");

	property p_measStartFall;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.state == ST_MEAS_WAIT) && !q.aclk && rxFall && !wrCtrl |=> q.run;
	endproperty
	a_measStartFall: assert property (p_measStartFall)
		else $error("falling edge did not start measurement");

	property p_measStartLow;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.state == ST_MEAS_WAIT) && q.aclk && !rxSync && !wrCtrl |=> q.run;
	endproperty
	a_measStartLow: assert property (p_measStartLow)
		else $error("low receive level did not start measurement");

	property p_arbRestart;
		@(posedge ref_clk) disable iff (!arst_n)
		((q.state == ST_ARB_WAIT) || (q.state == ST_ARB_RUN)) && txRise && !wrCtrl
			|=> q.run && (q.cnt == `SBAT_RST_CNT);
	endproperty
	a_arbRestart: assert property (p_arbRestart)
		else $error("transmit rising edge did not restart counter");

	property p_lostSet;
		@(posedge ref_clk) disable iff (!arst_n)
		s_sampleLow |=> s_lostSeen;
	endproperty
	a_lostSet: assert property (p_lostSet)
		else $error("low sample did not set lost and force pin");

	property p_forceHigh;
		@(posedge ref_clk) disable iff (!arst_n)
		q.lost |-> txPin;
	endproperty
	a_forceHigh: assert property (p_forceHigh)
		else $error("transmit pin not forced while lost");

	property p_earlyFall;
		@(posedge ref_clk) disable iff (!arst_n)
		(q.state == ST_ARB_RUN) && txFall && !q.seenLow && !setLost
			|=> !q.run && (q.cnt == `SBAT_RST_CNT);
	endproperty
	a_earlyFall: assert property (p_earlyFall)
		else $error("early transmit low did not reset counter");

endmodule : sbat_arbiter

`default_nettype wire

// file: verilog/sbat_defines.svh
`ifndef SBAT_DEFINES_SVH
`define SBAT_DEFINES_SVH

// Register offsets on the software port.
`define SBAT_OFS_CTRL 2'h0
`define SBAT_OFS_DATA 2'h1

// Field positions in the arbiter control register.
`define SBAT_BIT_AM1 7
`define SBAT_BIT_AM0 6
`define SBAT_BIT_LOST 5
`define SBAT_BIT_ACLK 4
`define SBAT_BIT_FIN 3
`define SBAT_BIT_RUN 2
`define SBAT_BIT_OVFL 1
`define SBAT_BIT_MSB 0

// Arbiter mode encodings.
`define SBAT_MODE_IDLE 2'h0
`define SBAT_MODE_MEAS 2'h1
`define SBAT_MODE_ARB 2'h2
`define SBAT_MODE_RSVD 2'h3

// Reset values.
`define SBAT_RST_MODE 2'h0
`define SBAT_RST_CNT 9'h000
`define SBAT_RST_DIV 2'h0
`define SBAT_RST_BYTE 8'h00
`define SBAT_RX_IDLE 1'b1
`define SBAT_TX_IDLE 1'b1

// Counter figures.
`define SBAT_CNT_ONE 9'h001
`define SBAT_CNT_MAX 9'h1FF
`define SBAT_DIV_ONE 2'h1
`define SBAT_DIV4_LAST 2'h3
`define SBAT_SAMPLE_BUS 9'h038
`define SBAT_SAMPLE_PSC 9'h008

`endif

// file: verilog/sbat_pkg.sv
`default_nettype none

package sbat_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MEAS_WAIT,
		ST_MEAS_RUN,
		ST_MEAS_DONE,
		ST_ARB_WAIT,
		ST_ARB_RUN
	} sbat_state_e;

	typedef struct packed {
		logic [1:0] mode;
		logic aclk;
		logic lost;
		logic fin;
		logic run;
		logic ovfl;
		logic [8:0] cnt;
		logic [1:0] div;
		logic pscHalf;
		logic rxPrev;
		logic txPrev;
		logic seenLow;
		sbat_state_e state;
		logic [7:0] rdata;
	} sbat_regs_s;

	typedef struct packed {
		logic meta;
		logic sync;
	} sbat_sync_s;

endpackage : sbat_pkg

`default_nettype wire

// file: verilog/sbat_rx_sync.sv
`include "sbat_defines.svh"
`default_nettype none

module sbat_rx_sync
	import sbat_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic rxRaw,
	output logic rxSync
);

	sbat_sync_s q, d;

	always_comb begin
		d = q;
		d.meta = rxRaw;
		d.sync = q.meta;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '{meta: `SBAT_RX_IDLE, sync: `SBAT_RX_IDLE};
		end else begin
			q <= d;
		end
	end

	assign rxSync = q.sync;

endmodule : sbat_rx_sync

`default_nettype wire
